// ==== bench/lss_master_model.sv ====
// model: configuration master sending requests and taking responses
`timescale 1ns/1ps
module lss_master_model (
  input  wire logic        i_clk,
  input  wire logic        i_tx_valid,
  input  wire logic [7:0]  i_tx_d0,
  output logic             o_rx_valid,
  output logic [10:0]      o_rx_id,
  output logic [3:0]       o_rx_len,
  output logic [7:0]       o_rx_d0,
  output logic [7:0]       o_rx_d1,
  output logic [7:0]       o_rx_d2,
  output logic             o_tx_ready
);
  // quiet lines at time zero
  initial begin
    o_rx_valid = 1'b0;
    o_tx_ready = 1'b0;
    {o_rx_id, o_rx_len, o_rx_d0, o_rx_d1, o_rx_d2} = '0;
  end
  // one-cycle request frame, caller picks id, length and bytes
  task automatic send(input logic [10:0] id, input logic [3:0] len, input logic [7:0] d0, d1, d2);
    @(negedge i_clk);
    o_rx_valid = 1'b1;
    {o_rx_id, o_rx_len, o_rx_d0, o_rx_d1, o_rx_d2} = {id, len, d0, d1, d2};
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    // stale fields inverted so they never pass for a frame
    {o_rx_id, o_rx_len, o_rx_d0, o_rx_d1, o_rx_d2} = ~{id, len, d0, d1, d2};
  endtask
  // wait for a response, stall, then take it at one edge
  task automatic take(input int stall, output logic ok, output logic [7:0] d0);
    int n;
    for (n = 0; n < 200 && i_tx_valid !== 1'b1; n++) @(negedge i_clk);
    repeat (stall) @(negedge i_clk);
    o_tx_ready = 1'b1;
    @(posedge i_clk);
    ok = i_tx_valid;
    d0 = i_tx_d0;
    @(negedge i_clk);
    o_tx_ready = 1'b0;
  endtask
endmodule

// ==== bench/lss_responder_asserts.sv ====
// checker: concurrent properties on the responder ports
`timescale 1ns/1ps
module lss_responder_asserts (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_rx_valid,
  input wire logic [10:0] i_rx_id,
  input wire logic [3:0]  i_rx_len,
  input wire logic [7:0]  i_rx_d0,
  input wire logic [7:0]  i_rx_d1,
  input wire logic [7:0]  i_rx_d2,
  input wire logic        i_tx_ready,
  input wire logic        o_tx_valid,
  input wire logic [10:0] o_tx_id,
  input wire logic [3:0]  o_tx_len,
  input wire logic [7:0]  o_tx_d0,
  input wire logic [7:0]  o_tx_d1,
  input wire logic [7:0]  o_tx_d2,
  input wire logic [7:0]  o_node_id,
  input wire logic [3:0]  o_rate_idx,
  input wire logic [19:0] o_rate_kbps,
  input wire logic        o_config_mode,
  input wire logic        o_tx_inhibit,
  input wire logic        o_node_reset
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic req;   // frame on the request identifier
  logic idle;  // configuring, nothing pending
  logic l2;    // two-byte frame
  logic l3;    // three-byte frame
  assign req  = i_rx_valid && i_rx_id == lss_pkg::REQ_ID;
  assign idle = o_config_mode && !o_tx_valid && !o_tx_inhibit;
  assign l2   = i_rx_len == lss_pkg::LEN_TWO;
  assign l3   = i_rx_len == lss_pkg::LEN_THREE;
  // rate index to kbit/s, zero when reserved
  function automatic logic [19:0] kbps(input logic [3:0] i);
    case (i)
      4'h0: return 20'h003E8;
      4'h1: return 20'h00320;
      4'h2: return 20'h001F4;
      4'h3: return 20'h000FA;
      4'h4: return 20'h0007D;
      4'h6: return 20'h00032;
      4'h7: return 20'h00014;
      4'h8: return 20'h0000A;
      default: return 20'h00000;
    endcase
  endfunction
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // request and inhibit sequences
  // ----------------------------------------
  sequence s_enter; req && l2 && i_rx_d0 == lss_pkg::CS_SWITCH && i_rx_d1 == lss_pkg::ARG_CONFIG; endsequence
  sequence s_leave;
    o_config_mode && req && l2 && i_rx_d0 == lss_pkg::CS_SWITCH && i_rx_d1 == lss_pkg::ARG_WAITING;
  endsequence
  sequence s_act0; idle && req && l3 && i_rx_d0 == lss_pkg::CS_ACTIVATE && {i_rx_d2, i_rx_d1} == 16'h0000; endsequence
  sequence s_hold2; o_tx_inhibit ##1 o_tx_inhibit ##1 !o_tx_inhibit; endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_rsp_frame_shape: assert property (o_tx_valid |-> o_tx_id == lss_pkg::RSP_ID && o_tx_len == lss_pkg::LEN_THREE
    && o_tx_d1 == 8'h00 && o_tx_d2 == 8'h00) else $error("response frame shape wrong");
  a_enter_config: assert property (s_enter |=> o_config_mode) else $error("config not entered");
  a_leave_reset: assert property (s_leave |=> !o_config_mode && o_node_reset) else $error("leave wrong");
  a_node_ack: assert property (idle && req && l2 && i_rx_d0 == lss_pkg::CS_NODE_ID
    |=> o_tx_valid && o_tx_d0 == lss_pkg::CS_NODE_ID) else $error("node id not acked");
  a_timing_ack: assert property (idle && req && l3 && i_rx_d0 == lss_pkg::CS_BIT_TIMING && i_rx_d1 == 8'h00
    |=> o_tx_valid && o_tx_d0 == lss_pkg::CS_BIT_TIMING) else $error("timing not acked");
  a_store_ack: assert property (idle && req && i_rx_len == lss_pkg::LEN_ONE && i_rx_d0 == lss_pkg::CS_STORE
    |=> o_tx_valid && o_tx_d0 == lss_pkg::CS_STORE) else $error("store not acked");
  a_silent_outside: assert property (!o_config_mode && !o_tx_valid && !o_tx_inhibit |=> !o_tx_valid)
    else $error("answer outside configuration");
  a_act_zero: assert property (s_act0 |=> s_hold2) else $error("zero-delay switch wrong");
  a_inhibit_quiet: assert property (o_tx_inhibit |-> !o_tx_valid) else $error("sent during switch");
  a_rate_pending: assert property ($changed(o_rate_idx) |-> $past(o_tx_inhibit))
    else $error("rate changed outside switch");
  a_node_pending: assert property ($changed(o_node_id) |-> $past(o_node_reset))
    else $error("node id changed early");
  a_rate_decode: assert property (o_rate_kbps == kbps($past(o_rate_idx))) else $error("rate decode wrong");
endmodule
bind lss_responder lss_responder_asserts u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx_valid(i_rx_valid),
  .i_rx_id(i_rx_id), .i_rx_len(i_rx_len), .i_rx_d0(i_rx_d0), .i_rx_d1(i_rx_d1), .i_rx_d2(i_rx_d2),
  .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid), .o_tx_id(o_tx_id), .o_tx_len(o_tx_len), .o_tx_d0(o_tx_d0),
  .o_tx_d1(o_tx_d1), .o_tx_d2(o_tx_d2), .o_node_id(o_node_id), .o_rate_idx(o_rate_idx),
  .o_rate_kbps(o_rate_kbps), .o_config_mode(o_config_mode), .o_tx_inhibit(o_tx_inhibit),
  .o_node_reset(o_node_reset));

// ==== bench/lss_responder_tb.sv ====
// testbench: self-checking run of the layer-setting responder
`timescale 1ns/1ps
module lss_responder_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int MS = lss_pkg::MS_CYCLES;  // cycles per delay unit
  localparam logic [19:0] KBPS [9] = '{20'h003E8, 20'h00320, 20'h001F4, 20'h000FA, 20'h0007D,
    20'h00000, 20'h00032, 20'h00014, 20'h0000A};
  logic        i_clk, i_rst_n, rx_valid, tx_ready, tx_valid, cfg, inh, nrst;
  logic [10:0] rx_id, tx_id;
  logic [3:0]  rx_len, rate, tx_len;
  logic [7:0]  d0, d1, d2, tx_d0, tx_d1, tx_d2, node;
  logic [19:0] kbps;
  int          error_cnt, total_checks;
  lss_responder DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx_valid(rx_valid), .i_rx_id(rx_id),
    .i_rx_len(rx_len), .i_rx_d0(d0), .i_rx_d1(d1), .i_rx_d2(d2), .i_tx_ready(tx_ready),
    .o_tx_valid(tx_valid), .o_tx_id(tx_id), .o_tx_len(tx_len), .o_tx_d0(tx_d0), .o_tx_d1(tx_d1), .o_tx_d2(tx_d2),
    .o_node_id(node), .o_rate_idx(rate), .o_rate_kbps(kbps), .o_config_mode(cfg),
    .o_tx_inhibit(inh), .o_node_reset(nrst));
  lss_master_model PM (.i_clk(i_clk), .i_tx_valid(tx_valid), .i_tx_d0(tx_d0), .o_rx_valid(rx_valid),
    .o_rx_id(rx_id), .o_rx_len(rx_len), .o_rx_d0(d0), .o_rx_d1(d1), .o_rx_d2(d2), .o_tx_ready(tx_ready));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic ack(input logic [7:0] cmd, input int stall);
    logic ok;
    logic [7:0] b;
    PM.take(stall, ok, b);
    check("ack seen", 20'h00001, {19'h0, ok});
    check("ack byte", {12'h000, cmd}, {12'h000, b});
    check("ack id", {9'h000, lss_pkg::RSP_ID}, {9'h000, tx_id});
    check("ack tail", 20'h30000, {tx_len, tx_d1, tx_d2});
  endtask
  task automatic silent();
    repeat (4) @(negedge i_clk);
    check("no answer", 20'h00000, {19'h0, tx_valid});
  endtask
  task automatic sw(input logic [7:0] arg);
    PM.send(lss_pkg::REQ_ID, lss_pkg::LEN_TWO, lss_pkg::CS_SWITCH, arg, 8'h00);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults();
    check("node", 20'h0007F, {12'h000, node});
    check("rate", {16'h0000, lss_pkg::RATE_125K}, {16'h0000, rate});
    check("kbps", 20'h0007D, kbps);
    $display("done defaults");
  endtask
  task automatic t_ignore();
    PM.send(lss_pkg::REQ_ID, lss_pkg::LEN_TWO, lss_pkg::CS_NODE_ID, 8'h33, 8'h00);
    silent();
    sw(lss_pkg::ARG_CONFIG);
    check("config", 20'h00001, {19'h0, cfg});
    PM.send(11'h7E6, lss_pkg::LEN_TWO, lss_pkg::CS_NODE_ID, 8'h33, 8'h00);
    silent();
    $display("done ignore");
  endtask
  task automatic t_node();
    PM.send(lss_pkg::REQ_ID, lss_pkg::LEN_TWO, lss_pkg::CS_NODE_ID, 8'h22, 8'h00);
    ack(lss_pkg::CS_NODE_ID, 3);
    check("node pending", 20'h0007F, {12'h000, node});
    PM.send(lss_pkg::REQ_ID, lss_pkg::LEN_ONE, lss_pkg::CS_STORE, 8'h00, 8'h00);
    ack(lss_pkg::CS_STORE, 0);
    sw(lss_pkg::ARG_WAITING);
    check("node reset", 20'h00001, {19'h0, nrst});
    check("left config", 20'h00000, {19'h0, cfg});
    @(negedge i_clk);
    check("node live", 20'h00022, {12'h000, node});
    $display("done node");
  endtask
  task automatic t_rates();
    logic [3:0] want;
    want = lss_pkg::RATE_125K;
    sw(lss_pkg::ARG_CONFIG);
    for (int i = 0; i < 9; i++) begin
      PM.send(lss_pkg::REQ_ID, lss_pkg::LEN_THREE, lss_pkg::CS_BIT_TIMING, lss_pkg::TABLE_SEL, 8'(i));
      ack(lss_pkg::CS_BIT_TIMING, i % 2);
      check("rate pending", {16'h0000, want}, {16'h0000, rate});
      PM.send(lss_pkg::REQ_ID, lss_pkg::LEN_THREE, lss_pkg::CS_ACTIVATE, 8'h00, 8'h00);
      repeat (4) @(negedge i_clk);
      if (i != 5) begin
        want = 4'(i);
      end
      check("rate", {16'h0000, want}, {16'h0000, rate});
      check("kbps", KBPS[want], kbps);
    end
    $display("done rates");
  endtask
  task automatic t_delay();
    int n;
    PM.send(lss_pkg::REQ_ID, lss_pkg::LEN_THREE, lss_pkg::CS_BIT_TIMING, lss_pkg::TABLE_SEL, 8'h03);
    ack(lss_pkg::CS_BIT_TIMING, 0);
    PM.send(lss_pkg::REQ_ID, lss_pkg::LEN_THREE, lss_pkg::CS_ACTIVATE, 8'h01, 8'h00);
    for (n = 0; n < 3 * MS && rate !== lss_pkg::RATE_250K; n++) @(posedge i_clk) #1;
    check("switch cycles", 20'(MS + 1), 20'(n));
    for (; n < 3 * MS && inh !== 1'b0; n++) @(posedge i_clk) #1;
    check("quiet cycles", 20'(2 * MS + 2), 20'(n));
    PM.send(lss_pkg::REQ_ID, lss_pkg::LEN_ONE, lss_pkg::CS_STORE, 8'h00, 8'h00);
    ack(lss_pkg::CS_STORE, 2);
    sw(lss_pkg::ARG_WAITING);
    check("rate kept", {16'h0000, lss_pkg::RATE_250K}, {16'h0000, rate});
    $display("done delay");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // hang guard beyond the longest switch
  initial begin
    repeat (2 * MS + 10000) @(posedge i_clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    i_rst_n = 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (3) @(negedge i_clk);
    t_defaults();
    t_ignore();
    t_node();
    t_rates();
    t_delay();
    end_of_test();
  end
endmodule

// ==== verilog/lss_nv_if.sv ====
// interface: link between responder and its settings store, which reset loads with the factory image
`timescale 1ns/1ps
interface lss_nv_if;
  logic       wr;        // one-cycle write strobe
  logic [7:0] wr_node;   // node id to save
  logic [3:0] wr_rate;   // rate index to save
  logic [7:0] rd_node;   // saved node id, registered
  logic [3:0] rd_rate;   // saved rate index, registered
  logic       rd_valid;  // saved image loaded after reset
  modport ctl (output wr, output wr_node, output wr_rate, input rd_node, input rd_rate, input rd_valid);
  modport mem (input wr, input wr_node, input wr_rate, output rd_node, output rd_rate, output rd_valid);
endinterface

// ==== verilog/lss_nv_store.sv ====
// module: settings store holding node id and rate index
`timescale 1ns/1ps
module lss_nv_store (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  lss_nv_if.mem     nv
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [7:0] node;        // saved node id
  logic [3:0] rate;        // saved rate index
  logic       valid;       // output valid flag
  logic [7:0] next_node;
  logic [3:0] next_rate;
  logic       next_valid;

  // next values: write updates the image
  always_comb begin
    next_node  = node;
    next_rate  = rate;
    next_valid = 1'b1;
    if (nv.wr) begin
      next_node = nv.wr_node;
      next_rate = nv.wr_rate;
    end
  end

  // registers, factory image at reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      node  <= lss_pkg::DEF_NODE_ID;
      rate  <= lss_pkg::RATE_125K;
      valid <= 1'b0;
    end else begin
      node  <= next_node;
      rate  <= next_rate;
      valid <= next_valid;
    end
  end

  assign nv.rd_node  = node;
  assign nv.rd_rate  = rate;
  assign nv.rd_valid = valid;
endmodule

// ==== verilog/lss_pkg.sv ====
// package: constants and types of the layer-setting-service responder
package lss_pkg;
  // ------------------------------------------------------------
  // frame identifiers
  // ------------------------------------------------------------
  localparam logic [10:0] REQ_ID        = 11'h7E5;   // master to device
  localparam logic [10:0] RSP_ID        = 11'h7E4;   // device to master
  // ------------------------------------------------------------
  // command bytes and arguments
  // ------------------------------------------------------------
  localparam logic [7:0]  CS_SWITCH     = 8'h04;     // switch state global
  localparam logic [7:0]  CS_NODE_ID    = 8'h11;     // configure node id
  localparam logic [7:0]  CS_BIT_TIMING = 8'h13;     // configure bit timing
  localparam logic [7:0]  CS_ACTIVATE   = 8'h15;     // activate bit timing
  localparam logic [7:0]  CS_STORE      = 8'h17;     // store configuration
  localparam logic [7:0]  ARG_CONFIG    = 8'h01;     // enter configuration
  localparam logic [7:0]  ARG_WAITING   = 8'h00;     // back to waiting
  localparam logic [7:0]  TABLE_SEL     = 8'h00;     // standard rate table
  localparam logic [7:0]  ACK_ZERO      = 8'h00;     // ack filler byte
  // ------------------------------------------------------------
  // lengths
  // ------------------------------------------------------------
  localparam logic [3:0]  LEN_ONE       = 4'h1;
  localparam logic [3:0]  LEN_TWO       = 4'h2;
  localparam logic [3:0]  LEN_THREE     = 4'h3;
  // ------------------------------------------------------------
  // defaults and rate indexes
  // ------------------------------------------------------------
  localparam logic [7:0]  DEF_NODE_ID   = 8'h7F;     // node id 127
  localparam logic [3:0]  RATE_1M       = 4'h0;
  localparam logic [3:0]  RATE_800K     = 4'h1;
  localparam logic [3:0]  RATE_500K     = 4'h2;
  localparam logic [3:0]  RATE_250K     = 4'h3;
  localparam logic [3:0]  RATE_125K     = 4'h4;      // default rate
  localparam logic [3:0]  RATE_RSVD     = 4'h5;      // reserved index
  localparam logic [3:0]  RATE_50K      = 4'h6;
  localparam logic [3:0]  RATE_20K      = 4'h7;
  localparam logic [3:0]  RATE_10K      = 4'h8;
  localparam logic [7:0]  RATE_MAX      = 8'h08;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          DELAY_UNIT_MS = 1;         // switch delay unit
  localparam int          MS_CYCLES     = CLK_HZ / 1000 * DELAY_UNIT_MS;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {LSS_WAITING, LSS_CONFIG} lss_mode_t;
  typedef enum logic [1:0] {SW_IDLE, SW_FIRST, SW_SECOND} lss_sw_t;
endpackage

// ==== verilog/lss_responder.sv ====
// module: layer-setting-service responder for node id and bit rate
`timescale 1ns/1ps
module lss_responder (
  input  wire logic        i_clk,          // 40 MHz
  input  wire logic        i_rst_n,        // async, active low
  input  wire logic        i_rx_valid,     // received frame strobe
  input  wire logic [10:0] i_rx_id,        // received identifier
  input  wire logic [3:0]  i_rx_len,       // received length
  input  wire logic [7:0]  i_rx_d0,        // data byte 0
  input  wire logic [7:0]  i_rx_d1,        // data byte 1
  input  wire logic [7:0]  i_rx_d2,        // data byte 2
  input  wire logic        i_tx_ready,     // controller takes response
  output logic             o_tx_valid,     // response pending
  output logic [10:0]      o_tx_id,        // response identifier
  output logic [3:0]       o_tx_len,       // response length
  output logic [7:0]       o_tx_d0,        // response byte 0
  output logic [7:0]       o_tx_d1,        // response byte 1
  output logic [7:0]       o_tx_d2,        // response byte 2
  output logic [7:0]       o_node_id,      // live node id
  output logic [3:0]       o_rate_idx,     // live rate index
  output logic [19:0]      o_rate_kbps,    // live rate in kbit/s
  output logic             o_config_mode,  // in configuration state
  output logic             o_tx_inhibit,   // no transmission during switch
  output logic             o_node_reset    // one-cycle reset to pre-operational
);
  // ------------------------------------------------------------
  // rate decode
  // ------------------------------------------------------------
  function automatic logic [19:0] rate_kbps(input logic [3:0] idx);
    case (idx)
      lss_pkg::RATE_1M:   rate_kbps = 20'h003E8;
      lss_pkg::RATE_800K: rate_kbps = 20'h00320;
      lss_pkg::RATE_500K: rate_kbps = 20'h001F4;
      lss_pkg::RATE_250K: rate_kbps = 20'h000FA;
      lss_pkg::RATE_125K: rate_kbps = 20'h0007D;
      lss_pkg::RATE_50K:  rate_kbps = 20'h00032;
      lss_pkg::RATE_20K:  rate_kbps = 20'h00014;
      lss_pkg::RATE_10K:  rate_kbps = 20'h0000A;
      default:            rate_kbps = 20'h00000;          // reserved
    endcase
  endfunction

  // ------------------------------------------------------------
  // store instance
  // ------------------------------------------------------------
  lss_nv_if nv ();
  lss_nv_store u_store (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .nv      (nv)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  lss_pkg::lss_mode_t mode, next_mode;         // waiting or configuration
  lss_pkg::lss_sw_t   sw, next_sw;             // bit-rate switch sequencer
  logic [7:0]  node, next_node;                // live node id
  logic [3:0]  rate, next_rate;                // live rate index
  logic [7:0]  pend_node, next_pend_node;      // pending node id
  logic [3:0]  pend_rate, next_pend_rate;      // pending rate index
  logic [15:0] delay, next_delay;              // switch delay in ms
  logic [15:0] ms_left, next_ms_left;          // ms still to wait
  logic [15:0] cyc, next_cyc;                  // cycles within one ms
  logic        loaded, next_loaded;            // image taken from store
  logic        tx_valid, next_tx_valid;
  logic [7:0]  tx_d0, next_tx_d0;
  logic        nv_wr, next_nv_wr;
  logic        node_reset, next_node_reset;
  logic        inhibit, next_inhibit;
  logic        out_valid, next_out_valid;      // response flag at the port
  logic        out_cfg, next_out_cfg;          // mode flag at the port

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  logic req;
  logic cfg;
  // only frames on the request identifier count
  assign req = i_rx_valid && (i_rx_id == lss_pkg::REQ_ID);
  assign cfg = (mode == lss_pkg::LSS_CONFIG);

  // next values of command handling
  always_comb begin
    next_mode       = mode;
    next_pend_node  = pend_node;
    next_pend_rate  = pend_rate;
    next_delay      = delay;
    // response drops at the edge that hands it over
    next_tx_valid   = tx_valid && !i_tx_ready;
    next_tx_d0      = tx_d0;
    next_nv_wr      = 1'b0;
    next_node_reset = 1'b0;
    next_loaded     = loaded || nv.rd_valid;
    if (!loaded && nv.rd_valid) begin
      // start-up copies saved image into pending
      next_pend_node = nv.rd_node;
      next_pend_rate = nv.rd_rate;
    end
    // switch state is taken in any state
    if (req && i_rx_d0 == lss_pkg::CS_SWITCH && i_rx_len == lss_pkg::LEN_TWO) begin
      if (i_rx_d1 == lss_pkg::ARG_CONFIG) begin
        next_mode = lss_pkg::LSS_CONFIG;
      end else if (i_rx_d1 == lss_pkg::ARG_WAITING) begin
        next_mode       = lss_pkg::LSS_WAITING;
        next_node_reset = cfg;
      end
    end else if (req && cfg && !tx_valid) begin
      // node id: kept pending, acked
      if (i_rx_d0 == lss_pkg::CS_NODE_ID && i_rx_len == lss_pkg::LEN_TWO) begin
        next_pend_node = i_rx_d1;
        next_tx_valid  = 1'b1;
        next_tx_d0     = lss_pkg::CS_NODE_ID;
      end else if (i_rx_d0 == lss_pkg::CS_BIT_TIMING && i_rx_len == lss_pkg::LEN_THREE &&
                   i_rx_d1 == lss_pkg::TABLE_SEL) begin
        // out-of-table index acked, not taken
        if (i_rx_d2 <= lss_pkg::RATE_MAX && i_rx_d2[3:0] != lss_pkg::RATE_RSVD) begin
          next_pend_rate = i_rx_d2[3:0];
        end
        next_tx_valid = 1'b1;
        next_tx_d0    = lss_pkg::CS_BIT_TIMING;
      end else if (i_rx_d0 == lss_pkg::CS_ACTIVATE && i_rx_len == lss_pkg::LEN_THREE &&
                   sw == lss_pkg::SW_IDLE) begin
        // delay kept for the second period
        next_delay = {i_rx_d2, i_rx_d1};
      end else if (i_rx_d0 == lss_pkg::CS_STORE && i_rx_len == lss_pkg::LEN_ONE) begin
        // saves pending values, not live ones
        next_nv_wr    = 1'b1;
        next_tx_valid = 1'b1;
        next_tx_d0    = lss_pkg::CS_STORE;
      end
    end
  end

  // activation start strobe
  // same terms as the activate branch, so the
  // sequencer never starts without the delay
  logic act;
  assign act = req && cfg && !tx_valid && i_rx_d0 == lss_pkg::CS_ACTIVATE &&
               i_rx_len == lss_pkg::LEN_THREE && sw == lss_pkg::SW_IDLE;

  // ------------------------------------------------------------
  // bit-rate switch sequencer
  // ------------------------------------------------------------
  // one tick for every ms of the clock
  logic ms_tick;
  assign ms_tick = (cyc == 16'(lss_pkg::MS_CYCLES - 1));

  // next values: two equal delay periods around the switch
  always_comb begin
    next_sw      = sw;
    next_ms_left = ms_left;
    // ms cycle count, cleared when idle and between periods
    next_cyc     = (sw == lss_pkg::SW_IDLE || ms_tick) ? 16'h0000 : 16'(cyc + 16'h0001);
    next_rate    = rate;
    next_node    = node;
    next_inhibit = inhibit;
    if (!loaded && nv.rd_valid) begin
      next_node = nv.rd_node;
      next_rate = nv.rd_rate;
    end
    // new node id goes live on leaving configuration
    if (node_reset) begin
      next_node = pend_node;
    end
    case (sw)
      lss_pkg::SW_IDLE: begin
        // idle until an activation is taken
        if (act) begin
          next_sw      = lss_pkg::SW_FIRST;
          next_ms_left = {i_rx_d2, i_rx_d1};
          next_inhibit = 1'b1;
        end
      end
      lss_pkg::SW_FIRST: begin
        // first period, then the switch
        if (ms_left == 16'h0000) begin
          next_rate    = pend_rate;
          next_ms_left = delay;
          next_sw      = lss_pkg::SW_SECOND;
          next_cyc     = 16'h0000;                                       // equal periods
        end else if (ms_tick) begin
          next_ms_left = 16'(ms_left - 16'h0001);
        end
      end
      lss_pkg::SW_SECOND: begin
        // second period, then release
        if (ms_left == 16'h0000) begin
          next_inhibit = 1'b0;
          next_sw      = lss_pkg::SW_IDLE;
        end else if (ms_tick) begin
          next_ms_left = 16'(ms_left - 16'h0001);
        end
      end
      default: begin
        next_sw = lss_pkg::SW_IDLE;
      end
    endcase
  end

  // registers of both groups
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode       <= lss_pkg::LSS_WAITING;
      sw         <= lss_pkg::SW_IDLE;
      node       <= lss_pkg::DEF_NODE_ID;
      rate       <= lss_pkg::RATE_125K;
      pend_node  <= lss_pkg::DEF_NODE_ID;
      pend_rate  <= lss_pkg::RATE_125K;
      delay      <= 16'h0000;
      ms_left    <= 16'h0000;
      cyc        <= 16'h0000;
      loaded     <= 1'b0;
      tx_valid   <= 1'b0;
      tx_d0      <= 8'h00;
      nv_wr      <= 1'b0;
      node_reset <= 1'b0;
      inhibit    <= 1'b0;
    end else begin
      mode       <= next_mode;
      sw         <= next_sw;
      node       <= next_node;
      rate       <= next_rate;
      pend_node  <= next_pend_node;
      pend_rate  <= next_pend_rate;
      delay      <= next_delay;
      ms_left    <= next_ms_left;
      cyc        <= next_cyc;
      loaded     <= next_loaded;
      tx_valid   <= next_tx_valid;
      tx_d0      <= next_tx_d0;
      nv_wr      <= next_nv_wr;
      node_reset <= next_node_reset;
      inhibit    <= next_inhibit;
    end
  end

  // next values of the port flags
  always_comb begin
    next_out_valid = next_tx_valid && !next_inhibit;
    next_out_cfg   = (next_mode == lss_pkg::LSS_CONFIG);
  end

  // port flag registers, so no port is a gate output
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_valid <= 1'b0;
      out_cfg   <= 1'b0;
    end else begin
      out_valid <= next_out_valid;
      out_cfg   <= next_out_cfg;
    end
  end

  // ------------------------------------------------------------
  // store and outputs
  // ------------------------------------------------------------
  // the store always receives the pending values
  assign nv.wr      = nv_wr;
  assign nv.wr_node = pend_node;
  assign nv.wr_rate = pend_rate;

  logic [19:0] kbps;                        // registered rate value
  // rate value register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kbps <= 20'h0007D;
    end else begin
      kbps <= rate_kbps(rate);
    end
  end

  // ports: id, length and filler bytes are fixed
  assign o_tx_valid    = out_valid;
  assign o_tx_id       = lss_pkg::RSP_ID;
  assign o_tx_len      = lss_pkg::LEN_THREE;
  assign o_tx_d0       = tx_d0;
  assign o_tx_d1       = lss_pkg::ACK_ZERO;
  assign o_tx_d2       = lss_pkg::ACK_ZERO;
  assign o_node_id     = node;
  assign o_rate_idx    = rate;
  assign o_rate_kbps   = kbps;
  assign o_config_mode = out_cfg;
  assign o_tx_inhibit  = inhibit;
  assign o_node_reset  = node_reset;
endmodule
